/* File: shared/dodc_pkg.sv */
// ----------------------------------------------------------------------
// driver control register constants
// ----------------------------------------------------------------------
package dodc_pkg;

    // bus and register geometry
    localparam int DODC_NUM_DRV = 6;
    localparam int DODC_ADDR_W = 12;
    localparam int DODC_DATA_W = 32;
    localparam int DODC_REG_W = 8;
    localparam int DODC_STORE_W = 5;

    // register indices; byte address is four times the index
    localparam logic [11:0] DODC_IDX_DRV0 = 12'h0F0;
    localparam logic [11:0] DODC_IDX_DRV1 = 12'h0F1;
    localparam logic [11:0] DODC_IDX_DRV2 = 12'h0F2;
    localparam logic [11:0] DODC_IDX_DRV3 = 12'h0F3;
    localparam logic [11:0] DODC_IDX_DRV4 = 12'h0F4;
    localparam logic [11:0] DODC_IDX_DRV5 = 12'h0F5;
    localparam logic [5:0][11:0] DODC_IDX_TABLE = {
        DODC_IDX_DRV5, DODC_IDX_DRV4, DODC_IDX_DRV3,
        DODC_IDX_DRV2, DODC_IDX_DRV1, DODC_IDX_DRV0
    };

    // field positions
    localparam int DODC_INV_BIT = 4;
    localparam int DODC_SWING_LSB = 2;
    localparam int DODC_PD_LSB = 0;

    // swing codes: 400, 600, 780 and 960 mV
    localparam logic [1:0] DODC_SWING_400 = 2'h0;
    localparam logic [1:0] DODC_SWING_600 = 2'h1;
    localparam logic [1:0] DODC_SWING_780 = 2'h2;
    localparam logic [1:0] DODC_SWING_960 = 2'h3;

    // power-down codes
    localparam logic [1:0] DODC_PD_NORMAL = 2'h0;
    localparam logic [1:0] DODC_PD_PART_A = 2'h1;
    localparam logic [1:0] DODC_PD_PART_B = 2'h2;
    localparam logic [1:0] DODC_PD_FULL = 2'h3;

    // reset values
    localparam logic DODC_RST_INV = 1'h0;
    localparam logic [1:0] DODC_RST_SWING = DODC_SWING_780;
    localparam logic [1:0] DODC_RST_PD_RUN = DODC_PD_NORMAL;
    localparam logic [1:0] DODC_RST_PD_PARK = DODC_PD_PART_B;
    localparam logic [31:0] DODC_RDATA_IDLE = 32'h0000_0000;

    // reset value of one stored register, even slots run, odd slots park
    function automatic logic [4:0] dodc_reset_val(input int idx);
        logic [1:0] pd;
        pd = (idx % 2 == 0) ? DODC_RST_PD_RUN : DODC_RST_PD_PARK;
        return {DODC_RST_INV, DODC_RST_SWING, pd};
    endfunction : dodc_reset_val

endpackage : dodc_pkg

/* File: shared/dodc_slot_if.sv */
`timescale 1ns/1ps
// ----------------------------------------------------------------------
// carrier between the register bank and one driver slot
// ----------------------------------------------------------------------
interface dodc_slot_if;
    logic wr_en;
    logic [4:0] wdata;
    logic [4:0] ctrl;
    logic invert;
    logic [1:0] swing;
    logic drv_on;
    logic partial_pd;
    logic full_pd;
    logic hiz;

    // bank side
    modport bank (
        output wr_en,
        output wdata,
        input ctrl,
        input invert,
        input swing,
        input drv_on,
        input partial_pd,
        input full_pd,
        input hiz
    );

    // slot side
    modport slot (
        input wr_en,
        input wdata,
        output ctrl,
        output invert,
        output swing,
        output drv_on,
        output partial_pd,
        output full_pd,
        output hiz
    );
endinterface : dodc_slot_if

/* File: logic/dodc_driver_slot.sv */
`timescale 1ns/1ps
// ----------------------------------------------------------------------
// one driver control register with registered decode
// ----------------------------------------------------------------------
module dodc_driver_slot
    import dodc_pkg::*;
#(
    parameter logic [4:0] RESET_VAL = 5'h08
)
(
    // clock and reset
    input logic pclk,
    input logic presetn,
    // bank connection
    dodc_slot_if.slot link
);
    import dodc_pkg::*;

    logic [4:0] next_ctrl;
    logic [1:0] next_pd;
    logic next_partial;
    logic next_full;

    // take the written value or hold; bits 7:5 never stored
    assign next_ctrl = link.wr_en ? link.wdata : link.ctrl; // see [R8]
    assign next_pd = next_ctrl[DODC_PD_LSB +: 2];
    // both middle codes mean partial power-down
    assign next_partial = (next_pd == DODC_PD_PART_A) ||
                          (next_pd == DODC_PD_PART_B); // see [R4]
    assign next_full = (next_pd == DODC_PD_FULL); // see [R5]

    // storage and decoded driver controls
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            link.ctrl <= RESET_VAL; // see [R2] see [R6] see [R7]
            link.invert <= RESET_VAL[DODC_INV_BIT];
            link.swing <= RESET_VAL[DODC_SWING_LSB +: 2];
            link.drv_on <= (RESET_VAL[1:0] == DODC_PD_NORMAL);
            link.partial_pd <= (RESET_VAL[1:0] == DODC_PD_PART_A) ||
                               (RESET_VAL[1:0] == DODC_PD_PART_B);
            link.full_pd <= (RESET_VAL[1:0] == DODC_PD_FULL);
            link.hiz <= (RESET_VAL[1:0] != DODC_PD_NORMAL);
        end
        else
        begin
            link.ctrl <= next_ctrl;
            link.invert <= next_ctrl[DODC_INV_BIT]; // see [R1]
            link.swing <= next_ctrl[DODC_SWING_LSB +: 2]; // see [R3]
            link.drv_on <= (next_pd == DODC_PD_NORMAL); // see [R4]
            link.partial_pd <= next_partial;
            link.full_pd <= next_full;
            link.hiz <= next_partial || next_full; // see [R4] see [R5]
        end
    end

endmodule : dodc_driver_slot

/* File: logic/dodc_top.sv */
// The APB interface to the registers was left to the implementer.
`timescale 1ns/1ps
// Functional notes
// [R1] Setting bit 4 of a driver register inverts that driver's clock.
// [R2] After reset every polarity bit reads zero, so no driver is inverted.
// [R3] Bits 3:2 pick 400, 600, 780 or 960 mV swing and reset to 780 mV.
// [R4] Code 00 runs the driver; 01 and 10 give partial power-down, hi-Z.
// [R5] Power-down code 11 gives full power-down with high-impedance outputs.
// [R6] The first, third and fifth drivers reset power-down to 00 and run.
// [R7] The second, fourth and sixth drivers reset power-down to 10, parked.
// [R8] Bits 7:5 ignore writes and read as zero.

// ----------------------------------------------------------------------
// six differential driver control registers behind an apb slave
// ----------------------------------------------------------------------
module dodc_top
    import dodc_pkg::*;
(
    // clock and reset
    input logic pclk,
    input logic presetn,
    // apb slave
    input logic psel,
    input logic penable,
    input logic pwrite,
    input logic [dodc_pkg::DODC_ADDR_W-1:0] paddr,
    input logic [dodc_pkg::DODC_DATA_W-1:0] pwdata,
    input logic [3:0] pstrb,
    output logic pready,
    output logic [dodc_pkg::DODC_DATA_W-1:0] prdata,
    output logic pslverr,
    // driver controls, one bit or pair per driver a to f
    output logic [dodc_pkg::DODC_NUM_DRV-1:0] drv_invert,
    output logic [2*dodc_pkg::DODC_NUM_DRV-1:0] drv_swing,
    output logic [dodc_pkg::DODC_NUM_DRV-1:0] drv_on,
    output logic [dodc_pkg::DODC_NUM_DRV-1:0] drv_partial_pd,
    output logic [dodc_pkg::DODC_NUM_DRV-1:0] drv_full_pd,
    output logic [dodc_pkg::DODC_NUM_DRV-1:0] drv_hiz
);
    import dodc_pkg::*;

    // ------------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------------
    logic [DODC_NUM_DRV-1:0] slot_hit;
    logic [DODC_STORE_W-1:0] slot_ctrl [DODC_NUM_DRV];
    logic [DODC_STORE_W-1:0] rd_field;
    logic addr_hit;
    logic setup_rd;
    logic access;
    logic wr_fire;

    // zero wait state slave: every access phase completes at once
    assign pready = 1'b1;
    assign access = psel && penable;
    assign setup_rd = psel && !penable && !pwrite;
    assign wr_fire = access && pwrite && pready && pstrb[0];
    assign addr_hit = |slot_hit;
    // unmapped addresses answer with an error and change nothing
    assign pslverr = access && !addr_hit;

    // ------------------------------------------------------------------
    // driver slots
    // ------------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < DODC_NUM_DRV; gi++)
        begin : g_slot
            localparam logic [11:0] BYTE_ADDR =
                {DODC_IDX_TABLE[gi][9:0], 2'h0};
            dodc_slot_if sif ();

            // one aligned word per register
            assign slot_hit[gi] = (paddr == BYTE_ADDR);
            assign sif.wr_en = wr_fire && slot_hit[gi];
            assign sif.wdata = pwdata[DODC_STORE_W-1:0]; // see [R8]
            assign slot_ctrl[gi] = sif.ctrl;

            // fan the decoded controls out to the pins
            assign drv_invert[gi] = sif.invert; // see [R1]
            assign drv_swing[2*gi +: 2] = sif.swing; // see [R3]
            assign drv_on[gi] = sif.drv_on;
            assign drv_partial_pd[gi] = sif.partial_pd; // see [R4]
            assign drv_full_pd[gi] = sif.full_pd; // see [R5]
            assign drv_hiz[gi] = sif.hiz;

            dodc_driver_slot #(
                .RESET_VAL(dodc_reset_val(gi))
            ) u_slot (
                .pclk(pclk),
                .presetn(presetn),
                .link(sif.slot)
            );
        end
    endgenerate

    // ------------------------------------------------------------------
    // read path
    // ------------------------------------------------------------------
    // select the addressed register, zero when nothing matches
    always_comb
    begin
        rd_field = '0;
        for (int i = 0; i < DODC_NUM_DRV; i++)
        begin
            if (slot_hit[i])
            begin
                rd_field = slot_ctrl[i];
            end
        end
    end

    // read data is captured in the setup cycle and stands until the next
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata <= DODC_RDATA_IDLE;
        end
        else if (setup_rd)
        begin
            prdata <= {27'h0, rd_field}; // see [R8]
        end
    end

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // helper: remember the slot that a write hit
    logic [2:0] wr_idx;
    always_comb
    begin
        wr_idx = 3'h0;
        for (int i = 0; i < DODC_NUM_DRV; i++)
        begin
            if (slot_hit[i])
            begin
                wr_idx = 3'(i);
            end
        end
    end

    // helper: first cycle after reset release
    logic rst_seen;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rst_seen <= 1'b0;
        end
        else
        begin
            rst_seen <= 1'b1;
        end
    end

    sequence s_write_hit;
        psel && penable && pwrite && pstrb[0] && addr_hit;
    endsequence

    sequence s_read_hit;
        psel && !penable && !pwrite && addr_hit
        ##1 psel && penable && !pwrite;
    endsequence

    sequence s_unmapped;
        psel && penable && !addr_hit;
    endsequence

    // polarity follows bit 4 of the written word
    chk_invert_write: assert property ( // see [R1]
        s_write_hit |=>
            drv_invert[$past(wr_idx)] == $past(pwdata[DODC_INV_BIT]))
        else $error("driver polarity did not follow the write");

    // all drivers non-inverted on the first cycle out of reset
    chk_invert_reset: assert property ( // see [R2]
        !rst_seen |-> drv_invert == '0)
        else $error("driver polarity not clear after reset");

    // swing follows bits 3:2 of the written word in the next cycle
    chk_swing_write: assert property ( // see [R3]
        s_write_hit |=>
            drv_swing[2*$past(wr_idx) +: 2] ==
            $past(pwdata[DODC_SWING_LSB +: 2]))
        else $error("driver swing did not follow the write");

    // every swing field starts at the 780 mV code
    chk_swing_reset: assert property ( // see [R3]
        !rst_seen |-> drv_swing == {DODC_NUM_DRV{DODC_RST_SWING}})
        else $error("driver swing reset value wrong");

    // middle codes park the driver in partial power-down, outputs floating
    chk_partial_pd: assert property ( // see [R4]
        s_write_hit ##0 (pwdata[1:0] == DODC_PD_PART_A ||
                         pwdata[1:0] == DODC_PD_PART_B) |=>
            drv_partial_pd[$past(wr_idx)] && drv_hiz[$past(wr_idx)] &&
            !drv_on[$past(wr_idx)] && !drv_full_pd[$past(wr_idx)])
        else $error("partial power-down not decoded");

    // code 00 runs the driver with its outputs driven, not high impedance
    chk_normal_run: assert property ( // see [R4]
        s_write_hit ##0 (pwdata[1:0] == DODC_PD_NORMAL) |=>
            drv_on[$past(wr_idx)] && !drv_hiz[$past(wr_idx)])
        else $error("normal operation not decoded");

    // code 11 fully powers the driver down
    chk_full_pd: assert property ( // see [R5]
        s_write_hit ##0 (pwdata[1:0] == DODC_PD_FULL) |=>
            drv_full_pd[$past(wr_idx)] && drv_hiz[$past(wr_idx)] &&
            !drv_partial_pd[$past(wr_idx)])
        else $error("full power-down not decoded");

    // even slots come out of reset running
    chk_reset_run: assert property ( // see [R6]
        !rst_seen |-> drv_on == 6'h15 && drv_hiz[0] == 1'b0)
        else $error("even drivers not running after reset");

    // odd slots come out of reset in partial power-down
    chk_reset_park: assert property ( // see [R7]
        !rst_seen |-> drv_partial_pd == 6'h2A && drv_hiz == 6'h2A &&
            drv_full_pd == '0)
        else $error("odd drivers not parked after reset");

    // upper bits of a read are always zero
    chk_upper_zero: assert property ( // see [R8]
        s_read_hit |-> prdata[7:5] == 3'h0 && pready)
        else $error("undefined bits read back nonzero");

    // a read returns what the last write left in the slot
    chk_read_back: assert property ( // see [R8]
        s_read_hit |-> prdata[4:0] == slot_ctrl[wr_idx])
        else $error("read data does not match the register");

    // unmapped access errors and leaves the polarity and swing of every driver alone
    chk_unmapped_err: assert property (
        s_unmapped |-> pslverr ##1 $stable(drv_invert) && $stable(drv_swing))
        else $error("unmapped access not refused");

    // neither on nor polarity of any driver moves without a bus write
    chk_no_spurious: assert property (
        !(access && pwrite) |=> $stable(drv_on) && $stable(drv_invert))
        else $error("driver control changed without a write");

    // on and floating are exact opposites at all times
    chk_on_vs_hiz: assert property ( // see [R4] see [R5]
        drv_on == ~drv_hiz)
        else $error("driver on and high impedance disagree");

    sequence s_strobe_off;
        psel && penable && pwrite && !pstrb[0];
    endsequence

    // a write with the low strobe clear leaves every driver alone
    chk_strobe_off: assert property (
        s_strobe_off |=> $stable(drv_invert) && $stable(drv_swing) &&
            $stable(drv_on) && $stable(drv_hiz))
        else $error("write with low strobe clear changed a driver");

    // the written slot stores only the low five bits of the word
    chk_write_store: assert property ( // see [R8]
        s_write_hit |=>
            slot_ctrl[$past(wr_idx)] == $past(pwdata[DODC_STORE_W-1:0]))
        else $error("written register does not hold the low bits");

    // a write to one slot leaves the polarity of the others alone
    chk_other_invert: assert property ( // see [R1]
        s_write_hit |=>
            (drv_invert & ~(6'h01 << $past(wr_idx))) ==
            ($past(drv_invert) & ~(6'h01 << $past(wr_idx))))
        else $error("write moved the polarity of another driver");

    // exactly one power state per driver at all times
    chk_pd_onehot: assert property ( // see [R4] see [R5]
        (drv_on | drv_partial_pd | drv_full_pd) == 6'h3F &&
        (drv_on & drv_partial_pd) == 6'h00 &&
        (drv_on & drv_full_pd) == 6'h00 &&
        (drv_partial_pd & drv_full_pd) == 6'h00)
        else $error("driver power states overlap or are missing");

    // every power-down state floats the outputs
    chk_pd_floats: assert property ( // see [R4] see [R5]
        ((drv_partial_pd | drv_full_pd) & ~drv_hiz) == 6'h00)
        else $error("powered-down driver not high impedance");

    // whole reset words of the running and the parked slots
    localparam logic [4:0] RUN_WORD =
        {DODC_RST_INV, DODC_RST_SWING, DODC_RST_PD_RUN};
    localparam logic [4:0] PARK_WORD =
        {DODC_RST_INV, DODC_RST_SWING, DODC_RST_PD_PARK};

    // even slots hold their whole reset word out of reset
    chk_reset_word_run: assert property ( // see [R6]
        !rst_seen |-> slot_ctrl[0] == RUN_WORD &&
            slot_ctrl[2] == RUN_WORD && slot_ctrl[4] == RUN_WORD)
        else $error("running slot reset word wrong");

    // odd slots hold their whole reset word out of reset
    chk_reset_word_park: assert property ( // see [R7]
        !rst_seen |-> slot_ctrl[1] == PARK_WORD &&
            slot_ctrl[3] == PARK_WORD && slot_ctrl[5] == PARK_WORD)
        else $error("parked slot reset word wrong");

    // upper read bits stay zero in every cycle
    chk_rdata_upper: assert property ( // see [R8]
        prdata[DODC_DATA_W-1:DODC_STORE_W] == 27'h0)
        else $error("read data upper bits nonzero");

    // an unmapped read returns zero data
    chk_unmapped_rd: assert property (
        psel && !penable && !pwrite && !addr_hit |=>
            prdata == DODC_RDATA_IDLE)
        else $error("unmapped read returned data");

    // mapped accesses never answer with an error
    chk_mapped_ok: assert property (
        access && addr_hit |-> !pslverr)
        else $error("mapped access answered with an error");

endmodule : dodc_top

/* File: test/tb_dodc_top.sv */
`timescale 1ns/1ps
// ----------------------------------------------------------------------
// bench for the six driver control registers
// ----------------------------------------------------------------------
module tb_dodc_top;
    import dodc_pkg::*;

    logic pclk = 1'h0;
    logic presetn = 1'h0;
    logic psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0] pstrb;
    logic [5:0] drv_invert, drv_on, drv_partial_pd, drv_full_pd, drv_hiz;
    logic [11:0] drv_swing;
    logic err;
    logic [4:0] model [6];
    int n_errors = 0;
    int checks_done = 0;
    int cycles = 0;

    // free running clock, 100 ns period
    always #50 pclk = ~pclk;

    dodc_top dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .drv_invert(drv_invert), .drv_swing(drv_swing), .drv_on(drv_on),
        .drv_partial_pd(drv_partial_pd), .drv_full_pd(drv_full_pd),
        .drv_hiz(drv_hiz)
    );

    // ------------------------------------------------------------------
    // reporting
    // ------------------------------------------------------------------
    task automatic complete_run;
        $display("checks %0d errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : complete_run

    task automatic check(input logic [31:0] seen, input logic [31:0] want,
                         input string what);
        checks_done++;
        if (seen !== want)
        begin
            n_errors++;
            $display("MISMATCH t=%0t %s seen %h want %h", $time, what, seen,
                     want);
        end
    endtask : check

    // hang guard, whole run needs about 530 cycles
    always @(posedge pclk)
    begin
        cycles++;
        if (cycles >= 5000)
        begin
            n_errors++;
            complete_run();
        end
    end

    // ------------------------------------------------------------------
    // apb master, request held until pready is seen high
    // ------------------------------------------------------------------
    task automatic apb_xfer(input logic wr, input logic [11:0] addr,
                            input logic [31:0] wdata, input logic [3:0] strb);
        psel <= 1'h1;
        penable <= 1'h0;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= wdata;
        pstrb <= strb;
        @(posedge pclk);
        penable <= 1'h1;
        @(posedge pclk);
        while (pready !== 1'h1)
            @(posedge pclk);
        rd = prdata;
        err = pslverr;
    endtask : apb_xfer

    // bus goes idle for one cycle
    task automatic apb_idle;
        psel <= 1'h0;
        penable <= 1'h0;
        @(posedge pclk);
    endtask : apb_idle

    // byte address of a driver register, four times its index
    function automatic logic [11:0] reg_addr(input int i);
        return {DODC_IDX_TABLE[i][9:0], 2'h0};
    endfunction : reg_addr

    // reset content: swing 780 mV, even drivers run, odd ones parked
    task automatic reset_model;
        for (int i = 0; i < 6; i++)
            model[i] = {1'h0, 2'h2, (i % 2 == 1) ? 2'h2 : 2'h0};
    endtask : reset_model

    // write one driver register and track what it should hold
    task automatic wr_reg(input int i, input logic [31:0] d,
                          input logic [3:0] strb);
        apb_xfer(1'h1, reg_addr(i), d, strb);
        check({31'h0, err}, 32'h0, "write error flag");
        if (strb[0])
            model[i] = d[4:0];
    endtask : wr_reg

    // ------------------------------------------------------------------
    // expected driver outputs decoded from the tracked registers
    // ------------------------------------------------------------------
    task automatic check_drv;
        logic [5:0] inv, on, part, full, hiz;
        logic [11:0] sw;
        for (int i = 0; i < 6; i++)
        begin
            inv[i] = model[i][4];
            sw[2*i +: 2] = model[i][3:2];
            on[i] = model[i][1:0] == 2'h0;
            part[i] = model[i][1:0] == 2'h1 || model[i][1:0] == 2'h2;
            full[i] = model[i][1:0] == 2'h3;
            hiz[i] = model[i][1:0] != 2'h0;
        end
        check(32'(drv_invert), 32'(inv), "invert");
        check(32'(drv_swing), 32'(sw), "swing");
        check(32'(drv_on), 32'(on), "on");
        check(32'(drv_partial_pd), 32'(part), "partial");
        check(32'(drv_full_pd), 32'(full), "full");
        check(32'(drv_hiz), 32'(hiz), "hiz");
    endtask : check_drv

    // read all six back to back, then the driver outputs
    task automatic check_regs;
        for (int i = 0; i < 6; i++)
        begin
            apb_xfer(1'h0, reg_addr(i), 32'h0, 4'h0);
            check(rd, {27'h0, model[i]}, "read");
            check({31'h0, err}, 32'h0, "read error flag");
        end
        apb_idle();
        check_drv();
    endtask : check_regs

    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial
    begin
        logic [31:0] d;
        logic [11:0] bad [5];
        int i;
        psel = 1'h0;
        penable = 1'h0;
        pwrite = 1'h0;
        paddr = 12'h000;
        pwdata = 32'h0;
        pstrb = 4'h0;
        bad = '{12'h000, 12'h3D8, 12'h3BC, 12'h3C1, 12'h3C6};
        void'($urandom(26));
        repeat (4) @(posedge pclk);
        presetn <= 1'h1;
        @(posedge pclk);
        reset_model();
        check_regs();
        // every swing and power-down code on every driver, back to back
        for (int c = 0; c < 16; c++)
        begin
            for (int k = 0; k < 6; k++)
            begin
                d = $urandom();
                d[4:0] = {c[0] ^ k[0], c[3:0]};
                wr_reg(k, d, 4'h1);
            end
            apb_idle();
            check_drv();
        end
        check_regs();
        // random writes, strobe low ignored, some read back at once
        for (int n = 0; n < 60; n++)
        begin
            i = $urandom_range(5);
            wr_reg(i, $urandom(), 4'($urandom()));
            if ($urandom_range(1) == 1)
            begin
                apb_xfer(1'h0, reg_addr(i), 32'h0, 4'h0);
                check(rd, {27'h0, model[i]}, "readback");
            end
            apb_idle();
            check_drv();
        end
        // unmapped and misaligned places refuse and change nothing
        foreach (bad[k])
        begin
            apb_xfer(1'h1, bad[k], 32'hFFFF_FFFF, 4'hF);
            check({31'h0, err}, 32'h1, "unmapped write error");
            apb_xfer(1'h0, bad[k], 32'h0, 4'h0);
            check({31'h0, err}, 32'h1, "unmapped read error");
            check(rd, 32'h0, "unmapped read data");
            apb_idle();
        end
        check_regs();
        // second reset in mid-run restores the defaults
        presetn <= 1'h0;
        repeat (2) @(posedge pclk);
        presetn <= 1'h1;
        @(posedge pclk);
        reset_model();
        check_regs();
        complete_run();
    end

endmodule : tb_dodc_top
